// [acrs_pkg.sv]
// Constants, register map and types shared by the readout sequencer
package acrs_pkg;
  // Bit positions of the synchronised pin vector
  localparam int unsigned PIN_CLEAR = 0;
  localparam int unsigned PIN_RSTRB = 1;
  localparam int unsigned PIN_SSTRB = 2;
  localparam int unsigned PIN_BW    = 3;
  localparam int unsigned PIN_START = 4;
  localparam int unsigned PIN_RCLK  = 5;
  localparam int unsigned PIN_PD_N  = 6;
  localparam int unsigned PIN_NAP_N = 7;
  localparam int unsigned PIN_HIZ   = 8;
  localparam int unsigned PIN_POL   = 9;
  localparam int unsigned PIN_MODE  = 10;
  localparam int unsigned PIN_RNG0  = 11;
  localparam int unsigned PIN_RNG1  = 12;
  localparam int unsigned PIN_RNG2  = 13;
  localparam int unsigned PIN_COUNT = 14;
  // Readout timing in readout clock edges
  localparam int unsigned TCNT_W          = 7;
  localparam logic [6:0]  SIMUL_RST_CLKS  = 7'h08;
  localparam logic [6:0]  SEQ_RST_CLKS    = 7'h20;
  localparam logic [6:0]  BYPASS_FALLS    = 7'h40;
  localparam logic [1:0]  SEQ_STEP_LAST   = 2'h3;
  localparam logic [1:0]  SEQ_SKEW_PHASE  = 2'h1;
  // Register map, byte addresses
  localparam int unsigned ADDR_W     = 4;
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_STATUS = 4'h4;
  localparam logic [3:0]  REG_CONFIG = 4'h8;
  localparam int unsigned DELAY_W        = 4;
  localparam logic [3:0]  CTRL_DELAY_RST = 4'h0;
  localparam int unsigned CTRL_DELAY_LSB = 0;
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_CNT_LSB   = 4;
  localparam int unsigned STAT_RST_SW    = 12;
  localparam int unsigned STAT_BYPASS    = 13;
  localparam int unsigned STAT_OUT_EN    = 14;
  localparam int unsigned STAT_EOC       = 15;
  localparam int unsigned CFG_RANGE_LSB  = 0;
  localparam int unsigned CFG_POL        = 4;
  localparam int unsigned CFG_SIMUL      = 5;
  localparam int unsigned CFG_BW         = 6;
  localparam int unsigned CFG_PD         = 7;
  localparam int unsigned CFG_NAP        = 8;
  localparam int unsigned CFG_HIZ_EN     = 9;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef enum logic [1:0] {
    RD_IDLE  = 2'b00,
    RD_ARMED = 2'b01,
    RD_SHIFT = 2'b10,
    RD_DONE  = 2'b11
  } acrs_rd_e;
endpackage

// [acrs_pin_sync.sv]
// Two-stage pin synchroniser with edge detection on the settled level
module acrs_pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level_out,
  output logic      [WIDTH-1:0] rise_out,
  output logic      [WIDTH-1:0] fall_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
  } acrs_sync_s;

  acrs_sync_s st;
  acrs_sync_s next_st;

  if (WIDTH < 1) begin : g_bad_width
    $error("acrs_pin_sync needs WIDTH of at least one");
  end

  // Only s2 feeds s3; s1 is read by nothing else
  always_comb begin
    next_st    = st;
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_out = st.s2;
  assign rise_out  = st.s2 & ~st.s3;
  assign fall_out  = ~st.s2 & st.s3;
endmodule

// [acrs_sequencer.sv]
// Readout and integration sequencer with AXI4-Lite status and control
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
module acrs_sequencer #(
  parameter int unsigned NUM_CHANNELS = 64
) (
  input  wire logic                      ref_clk_in,
  input  wire logic                      resetn_in,
  input  wire logic                      integrator_clear_in,
  input  wire logic                      reset_level_strobe_in,
  input  wire logic                      signal_level_strobe_in,
  input  wire logic                      sample_filter_bw_ctl_in,
  input  wire logic                      readout_start_in,
  input  wire logic                      readout_clk_in,
  input  wire logic                      powerdown_n_in,
  input  wire logic                      low_power_n_in,
  input  wire logic                      output_hiz_enable_in,
  input  wire logic                      polarity_select_in,
  input  wire logic                      output_mode_select_in,
  input  wire logic                      range_sel_bit2_in,
  input  wire logic                      range_sel_bit1_in,
  input  wire logic                      range_sel_bit0_in,
  output logic                           cascade_start_out,
  output logic                           end_of_conversion_out,
  output logic [$clog2(NUM_CHANNELS)-1:0] drv0_channel_out,
  output logic [$clog2(NUM_CHANNELS)-1:0] drv1_channel_out,
  output logic [1:0]                     analog_out_enable_out,
  output logic                           integrator_reset_sw_out,
  output logic                           filter_bypass_out,
  output logic                           reset_level_capture_out,
  output logic                           signal_level_capture_out,
  output logic                           filter_bw_high_out,
  output logic                           powerdown_out,
  output logic                           nap_out,
  output logic [2:0]                     range_out,
  output logic                           integrate_down_out,
  output logic                           simultaneous_out,
  input  wire logic [acrs_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic                      s_axi_awvalid_in,
  output logic                           s_axi_awready_out,
  input  wire logic [31:0]               s_axi_wdata_in,
  input  wire logic [3:0]                s_axi_wstrb_in,
  input  wire logic                      s_axi_wvalid_in,
  output logic                           s_axi_wready_out,
  output logic [1:0]                     s_axi_bresp_out,
  output logic                           s_axi_bvalid_out,
  input  wire logic                      s_axi_bready_in,
  input  wire logic [acrs_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic                      s_axi_arvalid_in,
  output logic                           s_axi_arready_out,
  output logic [31:0]                    s_axi_rdata_out,
  output logic [1:0]                     s_axi_rresp_out,
  output logic                           s_axi_rvalid_out,
  input  wire logic                      s_axi_rready_in
);
  localparam int unsigned CH_W   = $clog2(NUM_CHANNELS);
  localparam int unsigned CW     = CH_W - 1;
  localparam int unsigned HIST_N = 2 ** acrs_pkg::DELAY_W;
  localparam logic [CW-1:0] LAST_STEP = CW'((NUM_CHANNELS / 2) - 1);
  localparam logic [CH_W-1:0] HALF    = CH_W'(NUM_CHANNELS / 2);

  if (NUM_CHANNELS < 4 || (NUM_CHANNELS & (NUM_CHANNELS - 1)) != 0 || CW > 8) begin : g_bad_ch
    $error("NUM_CHANNELS must be a power of two from 4 to 512");
  end

  typedef struct packed {
    acrs_pkg::acrs_rd_e        rd;
    logic [CW-1:0]             cnt;
    logic [1:0]                phase;
    logic [CH_W-1:0]           drv0;
    logic [CH_W-1:0]           drv1;
    logic                      eoc;
    logic                      out_en;
    logic                      rst_sw;
    logic                      bypass;
    logic [acrs_pkg::TCNT_W-1:0] rise_cnt;
    logic [acrs_pkg::TCNT_W-1:0] fall_cnt;
    logic                      rcap;
    logic                      scap;
    logic                      bw;
    logic                      pd;
    logic                      nap;
    logic                      pol;
    logic                      simul;
    logic [2:0]                range;
    logic [HIST_N-1:0]         hist;
    logic                      cascade;
    logic [acrs_pkg::DELAY_W-1:0] delay;
    logic                      aw_ok;
    logic                      w_ok;
    logic [acrs_pkg::ADDR_W-1:0] awaddr;
    logic [31:0]               wdata;
    logic [3:0]                wstrb;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      rvalid;
    logic [31:0]               rdata;
    logic [1:0]                rresp;
  } acrs_seq_s;

  acrs_seq_s st;
  acrs_seq_s next_st;

  logic [acrs_pkg::PIN_COUNT-1:0] pin_raw;
  logic [acrs_pkg::PIN_COUNT-1:0] pin_q;
  logic [acrs_pkg::PIN_COUNT-1:0] pin_rise;
  logic [acrs_pkg::PIN_COUNT-1:0] pin_fall;
  logic                           rclk_rise;
  logic                           rclk_fall;
  logic                           start_rise;
  logic                           start_fall;
  logic                           seq_mode;

  always_comb begin
    pin_raw                       = '0;
    pin_raw[acrs_pkg::PIN_CLEAR]  = integrator_clear_in;
    pin_raw[acrs_pkg::PIN_RSTRB]  = reset_level_strobe_in;
    pin_raw[acrs_pkg::PIN_SSTRB]  = signal_level_strobe_in;
    pin_raw[acrs_pkg::PIN_BW]     = sample_filter_bw_ctl_in;
    pin_raw[acrs_pkg::PIN_START]  = readout_start_in;
    pin_raw[acrs_pkg::PIN_RCLK]   = readout_clk_in;
    pin_raw[acrs_pkg::PIN_PD_N]   = powerdown_n_in;
    pin_raw[acrs_pkg::PIN_NAP_N]  = low_power_n_in;
    pin_raw[acrs_pkg::PIN_HIZ]    = output_hiz_enable_in;
    pin_raw[acrs_pkg::PIN_POL]    = polarity_select_in;
    pin_raw[acrs_pkg::PIN_MODE]   = output_mode_select_in;
    pin_raw[acrs_pkg::PIN_RNG0]   = range_sel_bit0_in;
    pin_raw[acrs_pkg::PIN_RNG1]   = range_sel_bit1_in;
    pin_raw[acrs_pkg::PIN_RNG2]   = range_sel_bit2_in;
  end

  // Readout clock is oversampled, so it must stay below a quarter of ref_clk_in
  acrs_pin_sync #(
    .WIDTH (acrs_pkg::PIN_COUNT)
  ) u_pin_sync (
    .clk_in    (ref_clk_in),
    .resetn_in (resetn_in),
    .async_in  (pin_raw),
    .level_out (pin_q),
    .rise_out  (pin_rise),
    .fall_out  (pin_fall)
  );

  assign rclk_rise  = pin_rise[acrs_pkg::PIN_RCLK];
  assign rclk_fall  = pin_fall[acrs_pkg::PIN_RCLK];
  assign start_rise = pin_rise[acrs_pkg::PIN_START];
  assign start_fall = pin_fall[acrs_pkg::PIN_START];
  assign seq_mode   = !pin_q[acrs_pkg::PIN_MODE];

  always_comb begin
    logic [31:0] rword;
    logic [1:0]  rresp;
    logic [6:0]  rst_limit;
    rword     = '0;
    rresp     = acrs_pkg::RESP_OKAY;
    rst_limit = seq_mode ? acrs_pkg::SEQ_RST_CLKS : acrs_pkg::SIMUL_RST_CLKS;
    next_st   = st;

    // Static mode pins and level capture strobes
    next_st.bw    = pin_q[acrs_pkg::PIN_BW];
    next_st.pd    = !pin_q[acrs_pkg::PIN_PD_N];
    next_st.nap   = !pin_q[acrs_pkg::PIN_NAP_N];
    next_st.pol   = pin_q[acrs_pkg::PIN_POL];
    next_st.simul = !seq_mode;
    next_st.range = {pin_q[acrs_pkg::PIN_RNG2], pin_q[acrs_pkg::PIN_RNG1],
                     pin_q[acrs_pkg::PIN_RNG0]};
    next_st.rcap  = pin_rise[acrs_pkg::PIN_RSTRB];
    next_st.scap  = pin_rise[acrs_pkg::PIN_SSTRB];

    // Reset phase switches, counted in readout clock edges
    if (pin_rise[acrs_pkg::PIN_CLEAR]) begin
      next_st.rst_sw   = 1'b1;
      next_st.bypass   = 1'b1;
      next_st.rise_cnt = '0;
      next_st.fall_cnt = '0;
    end else begin
      if (st.rst_sw && rclk_rise) begin
        next_st.rise_cnt = st.rise_cnt + 7'h01;
        if (st.rise_cnt + 7'h01 >= rst_limit) begin
          next_st.rst_sw = 1'b0;
        end
      end
      if (st.bypass && rclk_fall) begin
        next_st.fall_cnt = st.fall_cnt + 7'h01;
        if (st.fall_cnt + 7'h01 == acrs_pkg::BYPASS_FALLS) begin
          next_st.bypass = 1'b0;
        end
      end
    end

    // Channel readout
    if (start_rise) begin
      next_st.rd    = acrs_pkg::RD_ARMED;
      next_st.cnt   = '0;
      next_st.phase = '0;
    end else begin
      case (st.rd)
        acrs_pkg::RD_IDLE: begin
          next_st.rd = acrs_pkg::RD_IDLE;
        end
        acrs_pkg::RD_ARMED: begin
          if (start_fall) begin
            next_st.rd   = acrs_pkg::RD_SHIFT;
            next_st.drv0 = '0;
            next_st.drv1 = HALF;
          end
        end
        acrs_pkg::RD_SHIFT: begin
          if (rclk_rise) begin
            next_st.phase = seq_mode ? st.phase + 2'h1 : '0;
            if (!seq_mode || st.phase == acrs_pkg::SEQ_STEP_LAST) begin
              if (st.cnt == LAST_STEP) begin
                next_st.rd = acrs_pkg::RD_DONE;
              end else begin
                next_st.cnt  = st.cnt + 1'b1;
                next_st.drv1 = HALF | CH_W'(st.cnt + 1'b1);
                if (!seq_mode) begin
                  next_st.drv0 = CH_W'(st.cnt + 1'b1);
                end
              end
            end
            // Driver 0 trails driver 1 by two readout clocks
            if (seq_mode && st.phase == acrs_pkg::SEQ_SKEW_PHASE) begin
              next_st.drv0 = CH_W'(st.cnt);
            end
          end
        end
        acrs_pkg::RD_DONE: begin
          next_st.rd = acrs_pkg::RD_DONE;
        end
        default: begin
          next_st.rd = acrs_pkg::RD_IDLE;
        end
      endcase
    end
    next_st.eoc    = next_st.rd != acrs_pkg::RD_SHIFT;
    next_st.out_en = !(pin_q[acrs_pkg::PIN_HIZ] && next_st.rd == acrs_pkg::RD_DONE);

    // Cascade copy: start level delayed by two cycles plus a software-set number of cycles
    next_st.hist    = {st.hist[HIST_N-2:0], pin_q[acrs_pkg::PIN_START]};
    next_st.cascade = st.hist[st.delay];

    // AXI4-Lite write path; address and data taken in either order
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      next_st.aw_ok  = 1'b1;
      next_st.awaddr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      next_st.w_ok  = 1'b1;
      next_st.wdata = s_axi_wdata_in;
      next_st.wstrb = s_axi_wstrb_in;
    end
    if (st.aw_ok && st.w_ok) begin
      next_st.aw_ok  = 1'b0;
      next_st.w_ok   = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = acrs_pkg::RESP_OKAY;
      case (st.awaddr)
        acrs_pkg::REG_CTRL: begin
          if (st.wstrb[0]) begin
            next_st.delay = st.wdata[acrs_pkg::CTRL_DELAY_LSB +: acrs_pkg::DELAY_W];
          end
        end
        acrs_pkg::REG_STATUS,
        acrs_pkg::REG_CONFIG: begin
          next_st.bresp = acrs_pkg::RESP_OKAY;
        end
        default: begin
          next_st.bresp = acrs_pkg::RESP_SLVERR;
        end
      endcase
    end else if (st.bvalid && s_axi_bready_in) begin
      next_st.bvalid = 1'b0;
    end

    // AXI4-Lite read path
    case (s_axi_araddr_in)
      acrs_pkg::REG_CTRL: begin
        rword[acrs_pkg::CTRL_DELAY_LSB +: acrs_pkg::DELAY_W] = st.delay;
      end
      acrs_pkg::REG_STATUS: begin
        rword[acrs_pkg::STAT_STATE_LSB +: 2] = st.rd;
        rword[acrs_pkg::STAT_CNT_LSB +: CW]  = st.cnt;
        rword[acrs_pkg::STAT_RST_SW]         = st.rst_sw;
        rword[acrs_pkg::STAT_BYPASS]         = st.bypass;
        rword[acrs_pkg::STAT_OUT_EN]         = st.out_en;
        rword[acrs_pkg::STAT_EOC]            = st.eoc;
      end
      acrs_pkg::REG_CONFIG: begin
        rword[acrs_pkg::CFG_RANGE_LSB +: 3] = st.range;
        rword[acrs_pkg::CFG_POL]            = st.pol;
        rword[acrs_pkg::CFG_SIMUL]          = st.simul;
        rword[acrs_pkg::CFG_BW]             = st.bw;
        rword[acrs_pkg::CFG_PD]             = st.pd;
        rword[acrs_pkg::CFG_NAP]            = st.nap;
        rword[acrs_pkg::CFG_HIZ_EN]         = pin_q[acrs_pkg::PIN_HIZ];
      end
      default: begin
        rresp = acrs_pkg::RESP_SLVERR;
      end
    endcase
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rword;
      next_st.rresp  = rresp;
    end else if (st.rvalid && s_axi_rready_in) begin
      next_st.rvalid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      st        <= '0;
      st.rd     <= acrs_pkg::RD_IDLE;
      st.eoc    <= 1'b1;
      st.out_en <= 1'b1;
      st.delay  <= acrs_pkg::CTRL_DELAY_RST;
    end else begin
      st <= next_st;
    end
  end

  // Ready terms are combinational so a held response blocks new requests
  assign s_axi_awready_out        = !st.aw_ok && !st.bvalid;
  assign s_axi_wready_out         = !st.w_ok && !st.bvalid;
  assign s_axi_arready_out        = !st.rvalid;
  assign s_axi_bvalid_out         = st.bvalid;
  assign s_axi_bresp_out          = st.bresp;
  assign s_axi_rvalid_out         = st.rvalid;
  assign s_axi_rdata_out          = st.rdata;
  assign s_axi_rresp_out          = st.rresp;
  assign cascade_start_out        = st.cascade;
  assign end_of_conversion_out    = st.eoc;
  assign drv0_channel_out         = st.drv0;
  assign drv1_channel_out         = st.drv1;
  assign analog_out_enable_out    = {st.out_en, st.out_en};
  assign integrator_reset_sw_out  = st.rst_sw;
  assign filter_bypass_out        = st.bypass;
  assign reset_level_capture_out  = st.rcap;
  assign signal_level_capture_out = st.scap;
  assign filter_bw_high_out       = st.bw;
  assign powerdown_out            = st.pd;
  assign nap_out                  = st.nap;
  assign range_out                = st.range;
  assign integrate_down_out       = st.pol;
  assign simultaneous_out         = st.simul;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!resetn_in);

  a_start_clears_cnt: assert property (start_rise |=> st.cnt == '0 && !end_of_conversion_out == 1'b0)
    else $error("start rise did not reset the channel counter");
  a_fall_begins_read: assert property (st.rd == acrs_pkg::RD_ARMED && start_fall && !start_rise
    |=> !end_of_conversion_out && drv1_channel_out == HALF)
    else $error("start fall did not begin the read");
  a_simul_advance: assert property (st.rd == acrs_pkg::RD_SHIFT && !seq_mode && rclk_rise
    && !start_rise && st.cnt != LAST_STEP |=> st.cnt == $past(st.cnt) + 1'b1)
    else $error("simultaneous mode missed an advance");
  a_seq_hold: assert property (st.rd == acrs_pkg::RD_SHIFT && seq_mode && rclk_rise
    && !start_rise && st.phase != acrs_pkg::SEQ_STEP_LAST |=> $stable(st.cnt))
    else $error("sequential mode advanced early");
  a_eoc_read: assert property ($fell(end_of_conversion_out) |-> $past(start_fall))
    else $error("end of conversion fell without a start fall");
  a_hiz_after_done: assert property (st.rd == acrs_pkg::RD_DONE && pin_q[acrs_pkg::PIN_HIZ]
    |=> analog_out_enable_out == 2'b00 || $past(start_rise))
    else $error("drivers not floated after readout");
  a_done_holds: assert property (st.rd == acrs_pkg::RD_DONE && !start_rise
    |=> $stable(st.cnt) && end_of_conversion_out)
    else $error("counter moved after the last channel");
  a_seq_skew: assert property (st.rd == acrs_pkg::RD_SHIFT && seq_mode && rclk_rise
    && !start_rise && st.phase == acrs_pkg::SEQ_SKEW_PHASE |=> drv0_channel_out == $past(st.cnt))
    else $error("driver 0 skew wrong");
  a_clear_closes: assert property (pin_rise[acrs_pkg::PIN_CLEAR] |=> integrator_reset_sw_out
    && filter_bypass_out && st.rise_cnt == '0)
    else $error("clear edge did not close the reset switch");
  a_bypass_opens: assert property (st.bypass && rclk_fall && !pin_rise[acrs_pkg::PIN_CLEAR]
    && st.fall_cnt == acrs_pkg::BYPASS_FALLS - 7'h01 |=> !filter_bypass_out)
    else $error("bypass did not open on the last falling edge");
  a_cascade_copy: assert property (st.delay == '0 ##1 st.delay == '0
    |-> cascade_start_out == $past(pin_q[acrs_pkg::PIN_START], 2))
    else $error("cascade output is not the delayed start");

  c_read_started: cover property (st.rd == acrs_pkg::RD_ARMED ##1 st.rd == acrs_pkg::RD_SHIFT);
  c_read_done_simul: cover property (st.rd == acrs_pkg::RD_SHIFT && !seq_mode
    ##1 st.rd == acrs_pkg::RD_DONE);
  c_read_done_seq: cover property (st.rd == acrs_pkg::RD_SHIFT && seq_mode
    ##1 st.rd == acrs_pkg::RD_DONE);
  c_axi_write: cover property (s_axi_bvalid_out && s_axi_bready_in);
endmodule

// [acrs_tctl_model.sv]
// Timing controller model making the readout clock
module acrs_tctl_model (
  input  wire logic clk_in,
  input  wire logic run_in,
  output logic      rclk_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] ph = 3'h0;
  // Four ref cycles a phase leaves margin for the pin synchroniser; idle low between frames
  always @(posedge clk_in) ph <= run_in ? ph + 3'h1 : 3'h0;
  assign rclk_out = ph[2];
endmodule

// [acrs_sequencer_tb.sv]
// Self-checking bench for the readout sequencer
module acrs_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst_n = 1'b0, clr = 1'b0, rs = 1'b0, ss = 1'b0, st = 1'b0;
  logic        bw = 1'b0, pd_n = 1'b1, nap_n = 1'b1, hz = 1'b0, pol = 1'b0, md = 1'b1;
  logic        run = 1'b0, aw = 1'b0, wv = 1'b0, br = 1'b0, ar = 1'b0, rr = 1'b0;
  logic [2:0]  rg = 3'h0, rgo;
  logic [3:0]  awa = 4'h0, ara = 4'h0;
  logic [31:0] wd = 32'h0000_0000, rd, d;
  logic [1:0]  bp, rp, oen, r;
  logic [5:0]  d0, d1;
  logic        rck, awr, wr, bv, arr, rv, cas, eoc, rsw, byp, rc, sc, fbw, pdo, npo, dn, smo;
  logic [16:0] seed = 17'h1_2d2f;
  int          num_errors = 0, num_checks = 0, cyc = 0, npr = 0, nps = 0, i, k, n;
  acrs_tctl_model CTL (.clk_in(clk), .run_in(run), .rclk_out(rck));
  acrs_sequencer DUT (.ref_clk_in(clk), .resetn_in(rst_n), .integrator_clear_in(clr),
    .reset_level_strobe_in(rs), .signal_level_strobe_in(ss), .sample_filter_bw_ctl_in(bw),
    .readout_start_in(st), .readout_clk_in(rck), .powerdown_n_in(pd_n), .low_power_n_in(nap_n),
    .output_hiz_enable_in(hz), .polarity_select_in(pol), .output_mode_select_in(md),
    .range_sel_bit2_in(rg[2]), .range_sel_bit1_in(rg[1]), .range_sel_bit0_in(rg[0]),
    .cascade_start_out(cas), .end_of_conversion_out(eoc), .drv0_channel_out(d0),
    .drv1_channel_out(d1), .analog_out_enable_out(oen), .integrator_reset_sw_out(rsw),
    .filter_bypass_out(byp), .reset_level_capture_out(rc), .signal_level_capture_out(sc),
    .filter_bw_high_out(fbw), .powerdown_out(pdo), .nap_out(npo), .range_out(rgo),
    .integrate_down_out(dn), .simultaneous_out(smo), .s_axi_awaddr_in(awa),
    .s_axi_awvalid_in(aw), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
    .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr),
    .s_axi_bresp_out(bp), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(ar), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rd), .s_axi_rresp_out(rp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr));
  initial forever #25 clk = ~clk;
  function automatic logic [16:0] nx(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic ck(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Handshakes judged on settled values mid-cycle, acted on at the next rise
  task automatic axw(input logic [3:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    @(posedge clk);
    {awa, wd, aw, wv, br} <= {a, v, 3'h7};
    do begin
      @(negedge clk);
      {ta, tw, tb} = {aw & awr, wv & wr, bv === 1'b1};
      r = bp;
      @(posedge clk);
      if (ta) aw <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (!tb);
    br <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] a);
    logic ta, tr;
    @(posedge clk);
    {ara, ar, rr} <= {a, 2'h3};
    do begin
      @(negedge clk);
      {ta, tr} = {ar & arr, rv === 1'b1};
      {d, r} = {rd, rp};
      @(posedge clk);
      if (ta) ar <= 1'b0;
    end while (!tr);
    rr <= 1'b0;
  endtask
  // Frame model: integer step counts, driver 0 lags two clocks in sequential mode
  task automatic frame(input logic m, input logic h);
    {md, hz, clr, rs, ss, st} <= {m, h, 4'hf};
    repeat (14) @(posedge clk);
    ck(cas, 1);
    ck(rsw, 1);
    {clr, rs, ss, st, bw} <= 5'h01;
    repeat (10) @(posedge clk);
    bw <= 1'b0;
    run <= 1'b1;
    n = m ? 32 : 128;
    repeat (2) @(posedge clk);
    for (k = 0; k < n + 4; k++) begin
      ck(eoc, k >= n);
      ck(d0, m ? (k > 31 ? 31 : k) : ((k - 2) / 4 > 31 ? 31 : (k - 2) / 4));
      ck(d1, 32 + (m ? (k > 31 ? 31 : k) : (k / 4 > 31 ? 31 : k / 4)));
      ck(rsw, k < (m ? 8 : 32));
      ck(byp, k < 65);
      ck(oen, (h && k >= n) ? 0 : 3);
      repeat (8) @(posedge clk);
    end
    run <= 1'b0;
    $display("frame test done, simultaneous %0d", m);
  endtask
  // Capture pulses counted mid-cycle to avoid racing the launching edge
  always @(negedge clk) begin
    npr <= npr + rc;
    nps <= nps + sc;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    ck(eoc, 1);
    for (i = 0; i < 4; i++) begin
      seed = nx(seed);
      {bw, pd_n, nap_n, pol, md, rg} <= seed[7:0];
      repeat (6) @(posedge clk);
      ck({fbw, pdo, npo, dn, smo, rgo}, {bw, ~pd_n, ~nap_n, pol, md, rg});
      ck(dn, pol);
    end
    axw(4'h0, 32'h0000_0005);
    ck(r, 0);
    axr(4'h0);
    ck(d, 5);
    axr(4'hc);
    ck({d[1:0], r}, 2);
    $display("register and pin test done");
    frame(1'b1, 1'b0);
    frame(1'b0, 1'b1);
    ck(npr, 2);
    ck(nps, 2);
    final_report();
  end
endmodule
